/* File: logic/wsst_pkg.sv */
// Purpose: constants for the wake and switch status bank
// Assumes: 8-bit registers, each one aligned APB word
// Notes: printed offsets are not all multiples of four, so byte address is four times the index
package wsst_pkg;
    localparam logic [6:0] WSST_IDX_WAKE_SRC = 7'h46;
    localparam logic [6:0] WSST_IDX_GPIO_WAKE = 7'h47;
    localparam logic [6:0] WSST_IDX_LEVEL = 7'h48;
    localparam logic [6:0] WSST_IDX_OVERLOAD = 7'h54;
    localparam logic [6:0] WSST_IDX_OPENLOAD = 7'h55;
    localparam logic [6:0] WSST_IDX_CONTROL = 7'h60;
    localparam logic [6:0] WSST_IDX_IRQ_STATUS = 7'h61;
    localparam logic [6:0] WSST_IDX_IRQ_MASK = 7'h62;
    localparam logic [7:0] WSST_WAKE_SRC_MASK = 8'h37;
    localparam logic [7:0] WSST_GPIO_WAKE_MASK = 8'h30;
    localparam logic [7:0] WSST_SWITCH_MASK = 8'h0F;
    localparam logic [7:0] WSST_RESET_VALUE = 8'h00;
    localparam int WSST_BUS_WAKE_BIT = 5;
    localparam int WSST_TIMER_WAKE_BIT = 4;
    localparam int WSST_GP_TWO_BIT = 5;
    localparam int WSST_GP_ONE_BIT = 4;
    localparam int WSST_DEV_MODE_BIT = 7;
    localparam int WSST_PULLUP_BIT = 6;
    localparam logic [4:0] WSST_IRQ_RESET = 5'h00;
    // gp pin mode codes on gpModeOne/Two
    localparam logic [1:0] WSST_GP_OFF = 2'h0;
    localparam logic [1:0] WSST_GP_WAKE = 2'h1;
    localparam logic [1:0] WSST_GP_SWITCH = 2'h2;
    localparam logic [1:0] WSST_GP_GENERAL = 2'h3;
    typedef enum logic [3:0]
    {
        WSST_ST_NORMAL = 4'h1,
        WSST_ST_STOP = 4'h2,
        WSST_ST_SLEEP = 4'h4,
        WSST_ST_FAILSAFE = 4'h8
    } wsst_mode_t;
endpackage

/* File: logic/wsst_status_bank.sv */
// Purpose: sticky wake and high-side diagnostic status registers, plus a non-sticky level register, behind APB
// Assumes: detector pulses come from logic on clk; pin levels and straps are asynchronous
// Notes: restart keeps sticky flags, only srst and clearing reads clear them
//
// Added by the designer: the APB slave port.
`timescale 1ns/100ps
module wsst_status_bank
    import wsst_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic clkEn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] deviceMode,
    input wire logic busWakeEvent,
    input wire logic timerWakeEvent,
    input wire logic [2:0] wakePinEvent,
    input wire logic [1:0] gpWakeEvent,
    input wire logic [2:0] wakePinPin,
    input wire logic [2:0] wakeSampleStrobe,
    input wire logic [2:0] wakeCyclic,
    input wire logic [1:0] gpPin,
    input wire logic [1:0] gpModeOne,
    input wire logic [1:0] gpModeTwo,
    input wire logic failOutputTestPin,
    input wire logic pullupConfigPin,
    input wire logic [3:0] switchOverloadEvent,
    input wire logic [3:0] switchOpenLoadEvent,
    input wire logic busSupplyLow,
    output logic busSupplyUndervoltage,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////
    logic [2:0] wakeMeta, wakeSync;
    logic [1:0] gpMeta, gpSync;
    logic [1:0] strapMeta, strapSync;
    logic uvMeta, uvSync;
    logic [7:0] wakeSrc, gpioWake, overload, openload, levelReg;
    logic transceiverOn;
    logic [4:0] irqStatus, irqMask;
    logic [7:0] next_wakeSrc, next_gpioWake, next_overload, next_openload;
    logic [4:0] irqEvents;
    logic [6:0] index;
    logic accessPhase, readNow, writeNow, mapped;
    logic [7:0] readByte;
    wsst_mode_t modeNow;

    assign modeNow = wsst_mode_t'(deviceMode);
    assign index = paddr[8:2];
    assign accessPhase = psel && penable && pready && clkEn;
    assign readNow = accessPhase && !pwrite && mapped;
    assign writeNow = accessPhase && pwrite && pstrb[0] && mapped;

    // two-stage synchronisers for every pin level
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            wakeMeta <= 3'h0;
            wakeSync <= 3'h0;
            gpMeta <= 2'h0;
            gpSync <= 2'h0;
            strapMeta <= 2'h0;
            strapSync <= 2'h0;
            uvMeta <= 1'b0;
            uvSync <= 1'b0;
        end
        else if (clkEn)
        begin
            wakeMeta <= wakePinPin;
            wakeSync <= wakeMeta;
            gpMeta <= gpPin;
            gpSync <= gpMeta;
            strapMeta <= {failOutputTestPin, pullupConfigPin};
            strapSync <= strapMeta;
            uvMeta <= busSupplyLow;
            uvSync <= uvMeta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky flags: reads of a flag register clear it, set wins
    always_comb
    begin
        next_wakeSrc = wakeSrc;
        next_gpioWake = gpioWake;
        next_overload = overload;
        next_openload = openload;
        // clear only what the read reported, so an event landing in the setup cycle is not wiped unseen
        if (readNow && index == WSST_IDX_WAKE_SRC)
            next_wakeSrc = wakeSrc & ~prdata[7:0];
        if (readNow && index == WSST_IDX_GPIO_WAKE)
            next_gpioWake = gpioWake & ~prdata[7:0];
        if (readNow && index == WSST_IDX_OVERLOAD)
            next_overload = overload & ~prdata[7:0];
        if (readNow && index == WSST_IDX_OPENLOAD)
            next_openload = openload & ~prdata[7:0];
        // wake detector also fires on a wake out of fail-safe
        next_wakeSrc[WSST_BUS_WAKE_BIT] = next_wakeSrc[WSST_BUS_WAKE_BIT] | busWakeEvent;
        next_wakeSrc[WSST_TIMER_WAKE_BIT] = next_wakeSrc[WSST_TIMER_WAKE_BIT] | timerWakeEvent;
        next_wakeSrc[2:0] = next_wakeSrc[2:0] | wakePinEvent;
        next_gpioWake[WSST_GP_TWO_BIT] = next_gpioWake[WSST_GP_TWO_BIT] | gpWakeEvent[1];
        next_gpioWake[WSST_GP_ONE_BIT] = next_gpioWake[WSST_GP_ONE_BIT] | gpWakeEvent[0];
        next_overload[3:0] = next_overload[3:0] | switchOverloadEvent;
        next_openload[3:0] = next_openload[3:0] | switchOpenLoadEvent;
    end

    // srst and clearing reads clear; a restart of the device does not touch these
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            wakeSrc <= WSST_RESET_VALUE;
            gpioWake <= WSST_RESET_VALUE;
            overload <= WSST_RESET_VALUE;
            openload <= WSST_RESET_VALUE;
        end
        else if (clkEn)
        begin
            wakeSrc <= next_wakeSrc & WSST_WAKE_SRC_MASK;
            gpioWake <= next_gpioWake & WSST_GPIO_WAKE_MASK;
            overload <= next_overload & WSST_SWITCH_MASK;
            openload <= next_openload & WSST_SWITCH_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // level register; reserved bit 3 held zero
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_wake_level
            always_ff @(posedge clk)
            begin
                if (srst)
                    levelReg[gi] <= 1'b0;
                else if (clkEn && (!wakeCyclic[gi] || wakeSampleStrobe[gi]))
                    levelReg[gi] <= wakeSync[gi];
            end
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            levelReg[7:3] <= 5'h00;
        end
        else if (clkEn)
        begin
            levelReg[3] <= 1'b0;
            levelReg[WSST_DEV_MODE_BIT] <= strapSync[1];
            levelReg[WSST_PULLUP_BIT] <= strapSync[0];
            // gp levels follow the synchronised pin in general mode, or in normal and stop when not off; never sampled cyclically
            if (gpModeOne == WSST_GP_GENERAL || (gpModeOne != WSST_GP_OFF &&
                (modeNow == WSST_ST_NORMAL || modeNow == WSST_ST_STOP)))
                levelReg[WSST_GP_ONE_BIT] <= gpSync[0];
            if (gpModeTwo == WSST_GP_GENERAL || (gpModeTwo != WSST_GP_OFF &&
                (modeNow == WSST_ST_NORMAL || modeNow == WSST_ST_STOP)))
                levelReg[WSST_GP_TWO_BIT] <= gpSync[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control register bit 0: transceiver mode bit gating the comparator
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            transceiverOn <= 1'b0;
            busSupplyUndervoltage <= 1'b0;
        end
        else if (clkEn)
        begin
            if (writeNow && index == WSST_IDX_CONTROL)
                transceiverOn <= pwdata[0];
            busSupplyUndervoltage <= transceiverOn && uvSync;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupts: one bit per flag register plus undervoltage, clear on read
    assign irqEvents = {busSupplyUndervoltage, |switchOpenLoadEvent, |switchOverloadEvent,
                        |gpWakeEvent, busWakeEvent | timerWakeEvent | (|wakePinEvent)};

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            irqStatus <= WSST_IRQ_RESET;
            irqMask <= WSST_IRQ_RESET;
            irq <= 1'b0;
        end
        else if (clkEn)
        begin
            if (readNow && index == WSST_IDX_IRQ_STATUS)
                irqStatus <= (irqStatus & ~prdata[4:0]) | irqEvents;
            else
                irqStatus <= irqStatus | irqEvents;
            if (writeNow && index == WSST_IDX_IRQ_MASK)
                irqMask <= pwdata[4:0];
            irq <= |(irqStatus & irqMask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave: no wait states, data and pready come from flops
    always_comb
    begin
        mapped = 1'b1;
        readByte = 8'h00;
        if (index == WSST_IDX_WAKE_SRC)
            readByte = wakeSrc;
        else if (index == WSST_IDX_GPIO_WAKE)
            readByte = gpioWake;
        else if (index == WSST_IDX_LEVEL)
            readByte = levelReg;
        else if (index == WSST_IDX_OVERLOAD)
            readByte = overload;
        else if (index == WSST_IDX_OPENLOAD)
            readByte = openload;
        else if (index == WSST_IDX_CONTROL)
            readByte = {7'h00, transceiverOn};
        else if (index == WSST_IDX_IRQ_STATUS)
            readByte = {3'h0, irqStatus};
        else if (index == WSST_IDX_IRQ_MASK)
            readByte = {3'h0, irqMask};
        else
            mapped = 1'b0;
        if (paddr[11:9] != 3'h0 || paddr[1:0] != 2'h0)
            mapped = 1'b0;
    end

    // pready pulses during the access phase so registers update on its edge
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (clkEn)
        begin
            pready <= psel && !pready;
            pslverr <= psel && !pready && !mapped;
            prdata <= (psel && !pready && !pwrite && mapped) ? {24'h00_0000, readByte} : 32'h0000_0000;
        end
    end
    // flag clear is tied to the completing edge: access phase seen with pready high
    ////////////////////////////////////////////////////////////////////////
    sequence wake_read_s;
        readNow && pready && index == WSST_IDX_WAKE_SRC && !busWakeEvent;
    endsequence

    sequence overload_read_s;
        readNow && index == WSST_IDX_OVERLOAD;
    endsequence

    // wake source and gp wake flags
    bus_wake_set_a: assert property (@(posedge clk) disable iff (srst)
        clkEn && busWakeEvent |=> wakeSrc[WSST_BUS_WAKE_BIT])
        else $error("bus wake flag not set");
    timer_wake_set_a: assert property (@(posedge clk) disable iff (srst)
        clkEn && timerWakeEvent |=> wakeSrc[WSST_TIMER_WAKE_BIT])
        else $error("timer wake flag not set");
    pin_wake_set_a: assert property (@(posedge clk) disable iff (srst)
        clkEn && wakePinEvent != 3'h0 |=> (wakeSrc[2:0] & $past(wakePinEvent)) == $past(wakePinEvent))
        else $error("wake pin flag not set");
    failsafe_wake_a: assert property (@(posedge clk) disable iff (srst)
        clkEn && modeNow == WSST_ST_FAILSAFE && busWakeEvent |=> wakeSrc[WSST_BUS_WAKE_BIT])
        else $error("wake out of fail-safe not flagged");
    gp_wake_a: assert property (@(posedge clk) disable iff (srst)
        clkEn && gpWakeEvent[1] |=> gpioWake[WSST_GP_TWO_BIT])
        else $error("gp wake flag not set");
    gp_one_wake_a: assert property (@(posedge clk) disable iff (srst)
        clkEn && gpWakeEvent[0] |=> gpioWake[WSST_GP_ONE_BIT])
        else $error("gp one wake flag not set");
    wake_clear_a: assert property (@(posedge clk) disable iff (srst)
        wake_read_s ##0 (wakePinEvent == 3'h0 && !timerWakeEvent) |=> (wakeSrc & $past(prdata[7:0])) == 8'h00)
        else $error("wake flags not cleared by read");
    wake_hold_a: assert property (@(posedge clk) disable iff (srst)
        wakeSrc[WSST_BUS_WAKE_BIT] && !(readNow && index == WSST_IDX_WAKE_SRC) |=> wakeSrc[WSST_BUS_WAKE_BIT])
        else $error("bus wake flag cleared itself");

    // high-side switch flags
    switch_set_a: assert property (@(posedge clk) disable iff (srst)
        clkEn && switchOverloadEvent[2] |=> overload[2])
        else $error("overload flag not set");
    openload_set_a: assert property (@(posedge clk) disable iff (srst)
        clkEn && switchOpenLoadEvent[0] |=> openload[0])
        else $error("open load flag not set");
    flag_holds_a: assert property (@(posedge clk) disable iff (srst)
        openload[1] && !(readNow && index == WSST_IDX_OPENLOAD) |=> openload[1])
        else $error("open load flag cleared itself");
    set_wins_a: assert property (@(posedge clk) disable iff (srst)
        readNow && index == WSST_IDX_OVERLOAD && switchOverloadEvent[3] |=> overload[3])
        else $error("event lost during clear");
    overload_clear_a: assert property (@(posedge clk) disable iff (srst)
        overload_read_s ##0 (switchOverloadEvent == 4'h0) |=> (overload & $past(prdata[7:0])) == 8'h00)
        else $error("overload flags not cleared by read");
    overload_hold_a: assert property (@(posedge clk) disable iff (srst)
        overload[0] && !(readNow && index == WSST_IDX_OVERLOAD) |=> overload[0])
        else $error("overload flag cleared itself");

    // reserved bits
    reserved_zero_a: assert property (@(posedge clk) disable iff (srst)
        wakeSrc[7:6] == 2'h0 && wakeSrc[3] == 1'b0 && gpioWake[3:0] == 4'h0 && overload[7:4] == 4'h0)
        else $error("reserved bit set");
    level_reserved_a: assert property (@(posedge clk) disable iff (srst)
        levelReg[3] == 1'b0 && gpioWake[7:6] == 2'h0)
        else $error("reserved level or gp wake bit set");
    switch_reserved_a: assert property (@(posedge clk) disable iff (srst)
        overload[7:4] == 4'h0 && openload[7:4] == 4'h0)
        else $error("upper switch status bit set");

    // level register
    level_follow_a: assert property (@(posedge clk) disable iff (srst)
        clkEn && !wakeCyclic[0] |=> levelReg[0] == $past(wakeSync[0]))
        else $error("wake pin level not followed");
    cyclic_hold_a: assert property (@(posedge clk) disable iff (srst)
        clkEn && wakeCyclic[1] && !wakeSampleStrobe[1] |=> $stable(levelReg[1]))
        else $error("cyclic level changed without a sample");
    cyclic_sample_a: assert property (@(posedge clk) disable iff (srst)
        clkEn && wakeCyclic[2] && wakeSampleStrobe[2] |=> levelReg[2] == $past(wakeSync[2]))
        else $error("cyclic level not sampled");
    gp_general_a: assert property (@(posedge clk) disable iff (srst)
        clkEn && gpModeOne == WSST_GP_GENERAL |=> levelReg[WSST_GP_ONE_BIT] == $past(gpSync[0]))
        else $error("general purpose level not shown");
    gp_sleep_hold_a: assert property (@(posedge clk) disable iff (srst)
        clkEn && gpModeOne == WSST_GP_SWITCH && modeNow == WSST_ST_SLEEP |=> $stable(levelReg[WSST_GP_ONE_BIT]))
        else $error("gp level refreshed in sleep");
    dev_level_a: assert property (@(posedge clk) disable iff (srst)
        clkEn && $past(clkEn) && $past(clkEn, 2) |=> levelReg[WSST_DEV_MODE_BIT] == $past(strapSync[1]))
        else $error("development level mismatch");
    pullup_level_a: assert property (@(posedge clk) disable iff (srst)
        clkEn |=> levelReg[WSST_PULLUP_BIT] == $past(strapSync[0]))
        else $error("pull-up strap level mismatch");

    // bus supply comparator
    uv_gate_a: assert property (@(posedge clk) disable iff (srst)
        busSupplyUndervoltage |-> $past(transceiverOn))
        else $error("undervoltage reported with transceiver off");
    uv_follow_a: assert property (@(posedge clk) disable iff (srst)
        clkEn && transceiverOn && uvSync |=> busSupplyUndervoltage)
        else $error("undervoltage not reported");
endmodule

/* File: tb/tb.sv */
// Purpose: self-checking bench for the wake and switch status bank over APB
// Assumes: one-cycle APB access with pready pulse, read clears flag registers
// Notes: reads queue their expected answer; a monitor compares when pready shows
`timescale 1ns/100ps
module tb;
    import wsst_pkg::*;
    logic clk, srst, clkEn, psel, penable, pwrite, busWakeEvent, timerWakeEvent;
    logic failOutputTestPin, pullupConfigPin, busSupplyLow;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, busSupplyUndervoltage, irq;
    logic [3:0] deviceMode, switchOverloadEvent, switchOpenLoadEvent;
    logic [2:0] wakePinEvent, wakePinPin, wakeSampleStrobe, wakeCyclic;
    logic [1:0] gpWakeEvent, gpPin, gpModeOne, gpModeTwo;
    logic [33:0] expQ[$];
    logic [33:0] expItem;
    logic [15:0] lfsr;
    int failures, checks, cycles;
    wsst_status_bank i_wsst_status_bank (.clk(clk), .srst(srst), .clkEn(clkEn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .deviceMode(deviceMode), .busWakeEvent(busWakeEvent), .timerWakeEvent(timerWakeEvent),
        .wakePinEvent(wakePinEvent), .gpWakeEvent(gpWakeEvent), .wakePinPin(wakePinPin),
        .wakeSampleStrobe(wakeSampleStrobe), .wakeCyclic(wakeCyclic), .gpPin(gpPin), .gpModeOne(gpModeOne),
        .gpModeTwo(gpModeTwo), .failOutputTestPin(failOutputTestPin), .pullupConfigPin(pullupConfigPin),
        .switchOverloadEvent(switchOverloadEvent), .switchOpenLoadEvent(switchOpenLoadEvent),
        .busSupplyLow(busSupplyLow), .busSupplyUndervoltage(busSupplyUndervoltage), .irq(irq));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [11:0] ad(input logic [6:0] idx);
        ad = {3'h0, idx, 2'h0};
    endfunction
    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        lfsr_next = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic finish_test();
        if (failures == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // called just after a rising edge; holds the request until pready is sampled
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [33:0] e);
        expQ.push_back(e);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge so the next call never re-drives psel in this time step
        @(posedge clk);
    endtask
    task automatic rd(input logic [6:0] idx, input logic [7:0] exp);
        apb(1'b0, ad(idx), 32'h0, {2'b10, 24'h0, exp});
    endtask
    task automatic wr(input logic [6:0] idx, input logic [7:0] d);
        apb(1'b1, ad(idx), {24'h0, d}, {2'b00, 32'h0});
    endtask
    task automatic pulse(input logic [1:0] bt, input logic [2:0] wp, input logic [1:0] gw, input logic [7:0] sw);
        {busWakeEvent, timerWakeEvent} <= bt;
        wakePinEvent <= wp;
        gpWakeEvent <= gw;
        {switchOverloadEvent, switchOpenLoadEvent} <= sw;
        @(posedge clk);
        {busWakeEvent, timerWakeEvent, wakePinEvent, gpWakeEvent} <= 7'h00;
        {switchOverloadEvent, switchOpenLoadEvent} <= 8'h00;
        repeat (2) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // monitor: every pready takes the oldest note off the queue
    always @(posedge clk)
        if (pready === 1'b1)
        begin
            if (expQ.size() == 0)
                check("unexpected pready", 32'h1, 32'h0);
            else
            begin
                expItem = expQ.pop_front();
                check("pslverr", {31'h0, pslverr}, {31'h0, expItem[32]});
                if (expItem[33])
                    check("prdata", prdata, expItem[31:0]);
            end
        end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            finish_test();
        end
    end
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {srst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 3'h0, 12'h0, 32'h0};
        {busWakeEvent, timerWakeEvent, wakePinEvent, gpWakeEvent, wakeSampleStrobe} = 10'h000;
        {switchOverloadEvent, switchOpenLoadEvent, busSupplyLow} = 9'h000;
        {wakePinPin, wakeCyclic, gpPin, failOutputTestPin, pullupConfigPin} = 10'h000;
        {gpModeOne, gpModeTwo} = {WSST_GP_GENERAL, WSST_GP_GENERAL};
        deviceMode = WSST_ST_NORMAL;
        clkEn = 1'b1;
        {failures, checks, cycles} = 0;
        lfsr = 16'hCD0E;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        rd(WSST_IDX_WAKE_SRC, 8'h00);
        rd(WSST_IDX_GPIO_WAKE, 8'h00);
        rd(WSST_IDX_OVERLOAD, 8'h00);
        rd(WSST_IDX_OPENLOAD, 8'h00);
        wr(WSST_IDX_IRQ_MASK, 8'h04);
        pulse(2'b11, 3'h7, 2'h0, 8'h00);
        repeat (200) @(posedge clk);
        rd(WSST_IDX_WAKE_SRC, 8'h37);
        rd(WSST_IDX_WAKE_SRC, 8'h00);
        for (int i = 0; i < 3; i++)
        begin
            pulse(2'b00, 3'h1 << i, 2'h0, 8'h00);
            rd(WSST_IDX_WAKE_SRC, 8'h01 << i);
        end
        deviceMode <= WSST_ST_FAILSAFE;
        pulse(2'b10, 3'h2, 2'h0, 8'h00);
        rd(WSST_IDX_WAKE_SRC, 8'h22);
        deviceMode <= WSST_ST_NORMAL;
        wr(WSST_IDX_WAKE_SRC, 8'hFF);
        rd(WSST_IDX_WAKE_SRC, 8'h00);
        pulse(2'b00, 3'h0, 2'h1, 8'h00);
        rd(WSST_IDX_GPIO_WAKE, 8'h10);
        pulse(2'b00, 3'h0, 2'h2, 8'h00);
        wr(WSST_IDX_GPIO_WAKE, 8'hCF);
        rd(WSST_IDX_GPIO_WAKE, 8'h20);
        for (int i = 0; i < 4; i++)
        begin
            lfsr = lfsr_next(lfsr);
            pulse(2'b00, 3'h0, 2'h0, lfsr[7:0]);
            rd(WSST_IDX_OVERLOAD, {4'h0, lfsr[7:4]});
            rd(WSST_IDX_OPENLOAD, {4'h0, lfsr[3:0]});
        end
        // a flag set in the very cycle of its clearing read must survive
        fork
            rd(WSST_IDX_OVERLOAD, 8'h00);
            begin
                @(posedge clk);
                switchOverloadEvent <= 4'h8;
                @(posedge clk);
                switchOverloadEvent <= 4'h0;
            end
        join
        rd(WSST_IDX_OVERLOAD, 8'h08);
        // interrupt: overload unmasked, open load masked
        rd(WSST_IDX_IRQ_STATUS, 8'h0F);
        pulse(2'b00, 3'h0, 2'h0, 8'h20);
        repeat (2) @(posedge clk);
        check("irq", {31'h0, irq}, 32'h1);
        rd(WSST_IDX_IRQ_STATUS, 8'h04);
        repeat (3) @(posedge clk);
        check("irq", {31'h0, irq}, 32'h0);
        pulse(2'b00, 3'h0, 2'h0, 8'h01);
        repeat (2) @(posedge clk);
        check("irq", {31'h0, irq}, 32'h0);
        rd(WSST_IDX_IRQ_STATUS, 8'h08);
        // level register, straps and pins
        {wakePinPin, gpPin, failOutputTestPin, pullupConfigPin} <= {3'b101, 2'b10, 2'b10};
        repeat (5) @(posedge clk);
        rd(WSST_IDX_LEVEL, 8'hA5);
        {wakeCyclic, wakePinPin, gpPin, failOutputTestPin, pullupConfigPin} <= {3'h7, 3'b010, 2'b01, 2'b01};
        repeat (5) @(posedge clk);
        rd(WSST_IDX_LEVEL, 8'h55);
        wakeSampleStrobe <= 3'h7;
        @(posedge clk);
        wakeSampleStrobe <= 3'h0;
        repeat (3) @(posedge clk);
        rd(WSST_IDX_LEVEL, 8'h52);
        {deviceMode, gpModeOne, gpModeTwo, gpPin} <= {WSST_ST_STOP, WSST_GP_SWITCH, WSST_GP_WAKE, 2'b10};
        repeat (5) @(posedge clk);
        rd(WSST_IDX_LEVEL, 8'h62);
        {deviceMode, gpModeOne, gpModeTwo, gpPin} <= {WSST_ST_SLEEP, WSST_GP_GENERAL, WSST_GP_GENERAL, 2'b11};
        repeat (5) @(posedge clk);
        rd(WSST_IDX_LEVEL, 8'h72);
        {deviceMode, gpModeOne, gpModeTwo, gpPin} <= {WSST_ST_SLEEP, WSST_GP_SWITCH, WSST_GP_OFF, 2'b00};
        repeat (5) @(posedge clk);
        rd(WSST_IDX_LEVEL, 8'h72);
        apb(1'b0, 12'h1FC, 32'h0, {2'b11, 32'h0});
        // misaligned write onto the control word must be refused and leave the transceiver bit alone
        apb(1'b1, 12'h181, 32'hFF, {2'b01, 32'h0});
        // comparator only runs with the transceiver mode bit set
        busSupplyLow <= 1'b1;
        repeat (6) @(posedge clk);
        check("busSupplyUndervoltage", {31'h0, busSupplyUndervoltage}, 32'h0);
        wr(WSST_IDX_CONTROL, 8'h01);
        repeat (3) @(posedge clk);
        check("busSupplyUndervoltage", {31'h0, busSupplyUndervoltage}, 32'h1);
        // with clkEn low the comparator output stays frozen although the supply recovers
        {clkEn, busSupplyLow} <= 2'b00;
        repeat (6) @(posedge clk);
        check("busSupplyUndervoltage", {31'h0, busSupplyUndervoltage}, 32'h1);
        clkEn <= 1'b1;
        repeat (5) @(posedge clk);
        check("busSupplyUndervoltage", {31'h0, busSupplyUndervoltage}, 32'h0);
        repeat (3) @(posedge clk);
        finish_test();
    end
endmodule
